// *** hw/dds_nco_serial_load.sv ***
/*
 * direct digital synthesis core with framed serial register load.
 * assumes serial pins and select pins are synchronous to clk_in (25 MHz)
 * and that the serial clock toggles slower than half of clk_in.
 */
`include "dds_params.svh"

module dds_nco_serial_load (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        sclk_in,
  input  wire logic        frame_sync_n_in,
  input  wire logic        serial_data_in,
  input  wire logic        freq_word_select_in,
  input  wire logic        phase_sel_lo_in,
  input  wire logic        phase_sel_hi_in,
  output wire logic [9:0]  dac_code_out
);
  serial_word_if        rx_link ();

  dds_pkg::freq_t       frequency_word [2];
  dds_pkg::phase_t      phase_offset_n [4];
  logic [15:0]          holding;
  logic [15:0]          next_holding;
  logic [15:0]          data_reg;
  logic                 dest_pending;
  logic                 dest_is_freq;
  logic [3:0]           dest_addr;
  logic                 fsel_bit;
  logic [1:0]           psel_bits;
  logic                 select_source;
  dds_pkg::freq_t       acc;
  dds_pkg::freq_t       step;
  dds_pkg::phase_t      lut_addr;
  dds_pkg::dac_code_t   lut_code;

  logic [3:0]           cmd;
  logic [3:0]           addr;
  logic [7:0]           data;
  logic                 is_defer;
  logic                 is_direct;
  logic                 direct_ok;
  logic                 fsel_eff;
  logic [1:0]           psel_eff;
  logic                 ctrl_cmd;
  logic                 clear_control;

  serial_word_rx u_rx (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .sclk_in         (sclk_in),
    .frame_sync_n_in (frame_sync_n_in),
    .serial_data_in  (serial_data_in),
    .link            (rx_link)
  );

  // word fields
  assign cmd  = rx_link.word[`CMD_MSB:`CMD_LSB];
  assign addr = rx_link.word[`ADDR_MSB:`ADDR_LSB];
  assign data = rx_link.word[`DATA_MSB:0];

  assign is_defer  = rx_link.valid &&
                     (cmd == `CMD_PHASE_DEFER || cmd == `CMD_FREQ_DEFER);
  assign is_direct = rx_link.valid &&
                     (cmd == `CMD_PHASE_DIRECT || cmd == `CMD_FREQ_DIRECT);
  // frequency commands reach addresses 0-7, phase commands 8-15
  assign direct_ok = (cmd == `CMD_FREQ_DIRECT) ? !addr[`ADDR_PHASE_BIT]
                                               : addr[`ADDR_PHASE_BIT];

  assign ctrl_cmd      = rx_link.valid &&
                         cmd[3:2] == `CMD_CTRL_TOP;
  assign clear_control = ctrl_cmd && rx_link.word[`BIT_CLEAR];

  // new byte merged into the held word, odd address takes the high byte
  always_comb begin
    next_holding = holding;
    if (addr[`ADDR_BYTE_BIT]) begin
      next_holding[15:8] = data;
    end else begin
      next_holding[7:0] = data;
    end
  end

  // holding register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      holding <= `HOLD_RESET;
    end else if (is_defer || is_direct) begin
      holding <= next_holding;
    end
  end

  // data register and pending destination
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_reg     <= `HOLD_RESET;
      dest_pending <= 1'b0;
      dest_is_freq <= 1'b0;
      dest_addr    <= 4'h0;
    end else begin
      dest_pending <= 1'b0;
      if (is_direct && direct_ok) begin
        data_reg     <= next_holding;
        dest_pending <= 1'b1;
        dest_is_freq <= (cmd == `CMD_FREQ_DIRECT);
        dest_addr    <= addr;
      end
    end
  end

  // frequency words: address bit 2 picks the word, bit 1 the half
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      frequency_word[0] <= `FREQ_RESET;
      frequency_word[1] <= `FREQ_RESET;
    end else if (dest_pending && dest_is_freq) begin
      if (dest_addr[`ADDR_HALF_BIT]) begin
        frequency_word[dest_addr[`ADDR_WORD_BIT]][31:16] <= data_reg;
      end else begin
        frequency_word[dest_addr[`ADDR_WORD_BIT]][15:0] <= data_reg;
      end
    end
  end

  // phase offsets: address bits 2:1 pick the register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        phase_offset_n[i] <= `PHASE_RESET;
      end
    end else if (dest_pending && !dest_is_freq) begin
      // upper nibble dropped; host keeps it zero
      phase_offset_n[dest_addr[2:1]] <= data_reg[11:0];
    end
  end

  // select bits written by the phase, frequency and both select commands
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fsel_bit  <= 1'b0;
      psel_bits <= 2'b00;
    end else if (rx_link.valid) begin
      if (cmd == `CMD_PHASE_SEL || cmd == `CMD_BOTH_SEL) begin
        psel_bits <= {rx_link.word[`BIT_PSEL_HI],
                      rx_link.word[`BIT_PSEL_LO]};
      end
      if (cmd == `CMD_FREQ_SEL || cmd == `CMD_BOTH_SEL) begin
        fsel_bit <= rx_link.word[`BIT_FSEL];
      end
    end
  end

  // select source: set or cleared by a control word, clear forces pins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      select_source <= 1'b0;
    end else if (clear_control) begin
      select_source <= 1'b0;
    end else if (ctrl_cmd) begin
      select_source <= rx_link.word[`BIT_SELECT_SOURCE];
    end
  end

  // pins or bits steer the selection
  assign fsel_eff = select_source ? fsel_bit
                                  : freq_word_select_in;
  assign psel_eff = select_source ? psel_bits
                                  : {phase_sel_hi_in,
                                     phase_sel_lo_in};

  assign step = frequency_word[fsel_eff];

  // accumulator: free running, wraps modulo two to the 32nd
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc <= `ACC_RESET;
    end else if (clear_control) begin
      acc <= `ACC_RESET;
    end else begin
      acc <= acc + step;
    end
  end

  // offset added to the top bits, then truncated to the table address
  assign lut_addr = acc[31:`PHASE_TOP_LSB] +
                    phase_offset_n[psel_eff];

  sine_lut u_lut (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .addr_in  (lut_addr),
    .code_out (lut_code)
  );

  assign dac_code_out = lut_code;

  sequence direct_f0_lo_s;
    rx_link.valid && cmd == `CMD_FREQ_DIRECT && addr[3:1] == 3'b000;
  endsequence

  sequence direct_any_s;
    is_direct && direct_ok;
  endsequence

  AST_ACC_STEP: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !clear_control |=> (acc - $past(acc)) == $past(step))
    else $error("accumulator did not advance by the step");

  AST_FREQ_COMMIT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    direct_f0_lo_s |-> ##2 frequency_word[0][15:0] ==
                              $past(next_holding, 2))
    else $error("frequency half not written two clocks after word");

  AST_DIRECT_PENDING: assert property (
    @(posedge clk_in) disable iff (rst_in)
    direct_any_s |=> dest_pending ##1 !dest_pending)
    else $error("direct write did not pend exactly one clock");

  AST_DEFER_NO_WRITE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    is_defer |=> !dest_pending && holding == $past(next_holding))
    else $error("defer write touched a destination");

  AST_PIN_SELECT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !select_source |-> step == (freq_word_select_in ? frequency_word[1]
                                                    : frequency_word[0]))
    else $error("frequency pin select not followed");

  AST_CLEAR_SOURCE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    clear_control |=> !select_source && acc == `ACC_RESET)
    else $error("clear did not return source to pins");

  AST_SEL_AFTER_WORD: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed(fsel_bit) || $changed(psel_bits) |-> $past(rx_link.valid))
    else $error("select bits changed without a word");

  AST_FREQ_HOLD: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed(fsel_eff) && !clear_control |=>
      (acc - $past(acc)) == $past(step))
    else $error("frequency switch disturbed the accumulator");

  sequence direct_p0_s;
    rx_link.valid && cmd == `CMD_PHASE_DIRECT && addr[3:1] == 3'b100;
  endsequence

  sequence direct_f1_hi_s;
    rx_link.valid && cmd == `CMD_FREQ_DIRECT && addr[3:1] == 3'b011;
  endsequence

  AST_PHASE_COMMIT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    direct_p0_s |-> ##2 phase_offset_n[0] ==
                          12'($past(next_holding, 2)))
    else $error("phase register zero not written after word");

  AST_FREQ_ONE_HIGH: assert property (
    @(posedge clk_in) disable iff (rst_in)
    direct_f1_hi_s |-> ##2 frequency_word[1][31:16] ==
                             $past(next_holding, 2))
    else $error("upper half of word one not written");

  AST_WRONG_DEST: assert property (
    @(posedge clk_in) disable iff (rst_in)
    is_direct && !direct_ok |=> !dest_pending)
    else $error("mismatched direct command wrote a register");

  AST_BITS_SELECT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    select_source |-> step == (fsel_bit ? frequency_word[1]
                                        : frequency_word[0]))
    else $error("frequency bit select not followed");

  AST_PSEL_PINS: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !select_source && phase_sel_hi_in && !phase_sel_lo_in |->
      (lut_addr - acc[31:`PHASE_TOP_LSB]) == phase_offset_n[2])
    else $error("phase pins did not pick offset two");

  AST_DEFER_BYTE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rx_link.valid && cmd == `CMD_FREQ_DEFER && addr[`ADDR_BYTE_BIT] |=>
      holding[15:8] == $past(data) &&
      holding[7:0] == $past(holding[7:0]))
    else $error("deferred byte not held in the upper half");

  AST_FSEL_BIT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rx_link.valid && cmd == `CMD_FREQ_SEL |=>
      fsel_bit == $past(rx_link.word[`BIT_FSEL]))
    else $error("frequency select bit not taken from word");
endmodule

// *** hw/dds_params.svh ***
/*
 * constants of the synthesiser core: command codes, word fields,
 * control bit positions, reset values and lookup constants.
 * assumes it is included by bare name and compiled before the design.
 */
// Operation
// - phase lives in a 32-bit accumulator that wraps over one full cycle
// - full accumulator range is one cycle; output rate is step times clock over two to the 32nd
// - phase step comes from frequency word zero or one
// - accumulator keeps running when the selected frequency word changes
// - selected 12-bit phase offset adds to the accumulator top bits
// - four phase offset registers, each one part in 4096 of a cycle
// - top 12 bits of the adjusted phase address the sine table
// - table output is a 10-bit code; address has two extra bits
// - each serial write carries exactly sixteen bits
// - bits are taken on serial clock falling edges, first bit first
// - serial clock may run freely or idle high or low between frames
// - word splits into 4-bit command, 4-bit address, 8-bit data
// - select 0 uses frequency word zero, select 1 word one
// - two phase select bits index the offset, high bit upper
// - defer commands fill the holding register; direct ones also write
// - direct write copies holding into data, destination next clock edge
// - holding, data and select transfers follow the sixteenth edge
// - select source bit picks pins or bits; clear returns it to pins
`ifndef DDS_PARAMS_SVH
`define DDS_PARAMS_SVH

`define WORD_MSB         15
`define CMD_MSB          15
`define CMD_LSB          12
`define ADDR_MSB         11
`define ADDR_LSB         8
`define DATA_MSB         7
`define BIT_COUNT_LAST   4'hf

`define CMD_PHASE_DIRECT 4'h0
`define CMD_PHASE_DEFER  4'h1
`define CMD_FREQ_DIRECT  4'h2
`define CMD_FREQ_DEFER   4'h3
`define CMD_PHASE_SEL    4'h4
`define CMD_FREQ_SEL     4'h5
`define CMD_BOTH_SEL     4'h6
`define CMD_CTRL_TOP     2'h3

`define BIT_PSEL_LO      9
`define BIT_PSEL_HI      10
`define BIT_FSEL         11
`define BIT_CLEAR        12
`define BIT_SELECT_SOURCE       13

`define ADDR_PHASE_BIT   3
`define ADDR_WORD_BIT    2
`define ADDR_HALF_BIT    1
`define ADDR_BYTE_BIT    0

`define FREQ_RESET       32'h0000_0000
`define PHASE_RESET      12'h000
`define HOLD_RESET       16'h0000
`define ACC_RESET        32'h0000_0000
`define PHASE_TOP_LSB    20

`define LUT_SPAN         21'h00_07ff
`define LUT_MID          10'h200
`define LUT_MID_LO       10'h1ff
`define LUT_ADDR_ZERO    12'h000

`endif

// *** hw/dds_pkg.sv ***
/*
 * types shared by the synthesiser core files.
 * assumes dds_params.svh supplies the numeric constants.
 */
package dds_pkg;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_SHIFT = 2'b01,
    RX_HOLD  = 2'b11
  } rx_state_t;

  typedef logic [9:0]  dac_code_t;
  typedef logic [11:0] phase_t;
  typedef logic [31:0] freq_t;
endpackage

// *** hw/serial_word_if.sv ***
/*
 * carries a received 16-bit serial word from the receiver to the core.
 * assumes both ends share one clock; valid is a one-cycle pulse.
 */
interface serial_word_if;
  logic [15:0] word;
  logic        valid;

  modport source (output word, output valid);
  modport sink   (input word, input valid);
endinterface

// *** hw/serial_word_rx.sv ***
/*
 * framed serial word receiver, sampled on the master clock.
 * assumes serial pins are synchronous to clk_in and slower than it.
 */
`include "dds_params.svh"

module serial_word_rx (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        sclk_in,
  input  wire logic        frame_sync_n_in,
  input  wire logic        serial_data_in,
  serial_word_if.source    link
);
  logic                sclk_prev;
  logic                sclk_fall;
  logic [3:0]          count;
  logic [15:0]         shift;
  dds_pkg::rx_state_t  state;

  // edge found from the last sample, whatever the idle level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_in;
    end
  end

  assign sclk_fall = sclk_prev & ~sclk_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= dds_pkg::RX_IDLE;
      count <= 4'h0;
      shift <= `HOLD_RESET;
    end else if (frame_sync_n_in) begin
      state <= dds_pkg::RX_IDLE;
      count <= 4'h0;
    end else begin
      case (state)
        dds_pkg::RX_IDLE, dds_pkg::RX_SHIFT: begin
          if (sclk_fall) begin
            shift <= {shift[14:0], serial_data_in};
            count <= count + 4'h1;
            state <= (count == `BIT_COUNT_LAST) ? dds_pkg::RX_HOLD
                                                : dds_pkg::RX_SHIFT;
          end
        end
        dds_pkg::RX_HOLD: begin
          state <= dds_pkg::RX_HOLD;
        end
        default: begin
          state <= dds_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // word handed over on the sixteenth falling edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      link.valid <= 1'b0;
      link.word  <= `HOLD_RESET;
    end else begin
      link.valid <= 1'b0;
      if (!frame_sync_n_in && sclk_fall && state != dds_pkg::RX_HOLD &&
          count == `BIT_COUNT_LAST) begin
        link.valid <= 1'b1;
        link.word  <= {shift[14:0], serial_data_in};
      end
    end
  end

  sequence last_bit_s;
    !frame_sync_n_in && sclk_fall && count == `BIT_COUNT_LAST &&
      state == dds_pkg::RX_SHIFT;
  endsequence

  AST_RX_SIXTEENTH: assert property (
    @(posedge clk_in) disable iff (rst_in)
    last_bit_s |=> link.valid && state == dds_pkg::RX_HOLD)
    else $error("word not delivered on sixteenth edge");

  AST_RX_ONE_WORD: assert property (
    @(posedge clk_in) disable iff (rst_in)
    link.valid |=> !link.valid [*2])
    else $error("more than one word in a frame");

  AST_RX_LAST_BIT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    link.valid |-> link.word[0] == $past(serial_data_in) &&
                   link.word[1] == $past(shift[0]))
    else $error("bit order wrong in received word");

  AST_RX_ABORT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    frame_sync_n_in |=> state == dds_pkg::RX_IDLE && count == 4'h0)
    else $error("frame end did not reset the receiver");
endmodule

// *** hw/sine_lut.sv ***
/*
 * sine amplitude table: 12-bit phase in, registered 10-bit code out.
 * assumes offset binary output; quarter wave folded with a parabola.
 */
`include "dds_params.svh"

module sine_lut (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire dds_pkg::phase_t    addr_in,
  output dds_pkg::dac_code_t      code_out
);
  logic [9:0]  fold;
  logic [20:0] prod;
  logic [8:0]  half;

  // second and fourth quarters read the quarter wave backwards
  assign fold = addr_in[10] ? ~addr_in[9:0] : addr_in[9:0];
  assign prod = 21'(fold) * (`LUT_SPAN - 21'(fold));
  assign half = prod[19:11];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      code_out <= `LUT_MID;
    end else if (addr_in[11]) begin
      code_out <= `LUT_MID_LO - {1'b0, half};
    end else begin
      code_out <= `LUT_MID + {1'b0, half};
    end
  end

  AST_LUT_ZERO: assert property (
    @(posedge clk_in) disable iff (rst_in)
    addr_in == `LUT_ADDR_ZERO |=> code_out == `LUT_MID)
    else $error("zero phase does not give mid scale");
endmodule

// *** tb/serial_host.sv ***
/*
 * host side of the framed serial write port: sends one word per call.
 * assumes the caller waits on clk_in; clk_in is the device master clock.
 */
module serial_host (
  input  wire logic clk_in,
  output logic      sclk_out,
  output logic      frame_sync_n_out,
  output logic      serial_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk_out         = 1'b0;
    frame_sync_n_out = 1'b1;
    serial_data_out  = 1'b0;
  end

  task automatic half();
    repeat (2) @(posedge clk_in);
  endtask

  // nbits above sixteen gives extra falling edges inside the frame
  task automatic send(input logic [15:0] word, input int nbits,
                      input logic idle_hi);
    logic [15:0] sr;
    sr = word;
    if (word[15:13] == 3'h0 && word[11] && word[8]) begin
      sr[7:4] = 4'h0;
    end
    @(posedge clk_in);
    sclk_out <= idle_hi;
    half();
    frame_sync_n_out <= 1'b0;
    half();
    for (int i = 0; i < nbits; i++) begin
      sclk_out        <= 1'b1;
      serial_data_out <= sr[15];
      sr = {sr[14:0], 1'b1};
      half();
      sclk_out <= 1'b0;
      half();
    end
    frame_sync_n_out <= 1'b1;
    sclk_out         <= idle_hi;
    serial_data_out  <= ~serial_data_out;
    half();
  endtask
endmodule

// *** tb/test_dds_nco_serial_load.sv ***
/*
 * self-checking bench for the synthesiser core, judged at dac_code_out.
 * assumes the sine code equals mid scale at phase zero, lies above it in
 * the first half cycle and below it in the second.
 */
`include "dds_params.svh"

module test_dds_nco_serial_load;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [1:0] cls_mid  = 2'h0;
  localparam logic [1:0] cls_up   = 2'h1;
  localparam logic [1:0] cls_down = 2'h2;

  logic               clk_in;
  logic               rst_in;
  logic               sclk;
  logic               frame_sync_n;
  logic               serial_data;
  logic               freq_word_select;
  logic               phase_sel_lo;
  logic               phase_sel_hi;
  dds_pkg::dac_code_t dac_code;
  logic               idle;
  int                 miscompares;
  int                 n_tests;

  dds_nco_serial_load u_dds_nco_serial_load (
    .clk_in              (clk_in),
    .rst_in              (rst_in),
    .sclk_in             (sclk),
    .frame_sync_n_in     (frame_sync_n),
    .serial_data_in      (serial_data),
    .freq_word_select_in (freq_word_select),
    .phase_sel_lo_in     (phase_sel_lo),
    .phase_sel_hi_in     (phase_sel_hi),
    .dac_code_out        (dac_code)
  );

  serial_host u_serial_host (
    .clk_in           (clk_in),
    .sclk_out         (sclk),
    .frame_sync_n_out (frame_sync_n),
    .serial_data_out  (serial_data)
  );

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [1:0] cls(input dds_pkg::dac_code_t c);
    if (c === `LUT_MID) return cls_mid;
    else if (c > `LUT_MID) return cls_up;
    else if (c < `LUT_MID) return cls_down;
    return 2'h3;
  endfunction

  task automatic settle();
    repeat (8) @(posedge clk_in);
  endtask

  task automatic wr(input logic [3:0] cmd, input logic [3:0] addr,
                    input logic [7:0] data, input int nbits = 16);
    idle = ~idle;
    u_serial_host.send({cmd, addr, data}, nbits, idle);
  endtask

  task automatic load_phase(input int k, input logic [11:0] v);
    wr(`CMD_PHASE_DEFER, 4'(8 + 2 * k), v[7:0]);
    wr(`CMD_PHASE_DIRECT, 4'(9 + 2 * k), {4'h0, v[11:8]});
  endtask

  task automatic pick(input int k);
    @(posedge clk_in);
    phase_sel_lo <= k[0];
    phase_sel_hi <= k[1];
    settle();
  endtask

  task automatic look(input string what, input logic [1:0] exp);
    check(what, 16'(cls(dac_code)), 16'(exp));
  endtask

  task automatic step(input int n);
    @(posedge clk_in);
    freq_word_select <= 1'b1;
    repeat (n) @(posedge clk_in);
    freq_word_select <= 1'b0;
    settle();
  endtask

  task automatic t_phase();
    logic [11:0] vals [4] = '{12'h400, 12'hc00, 12'h000, 12'h300};
    logic [1:0]  exp [4] = '{cls_up, cls_down, cls_mid, cls_up};
    for (int k = 0; k < 4; k++) load_phase(k, vals[k]);
    for (int k = 0; k < 4; k++) begin
      pick(k);
      look("phase offset", exp[k]);
    end
    $display("test phase offsets done");
  endtask

  task automatic t_defer();
    wr(`CMD_PHASE_DEFER, 4'h9, 8'h0c);
    pick(0);
    look("defer only", cls_up);
    $display("test deferred write done");
  endtask

  task automatic t_frame();
    pick(2);
    wr(`CMD_PHASE_DIRECT, 4'hd, 8'h0c, 10);
    settle();
    look("aborted frame", cls_mid);
    wr(`CMD_PHASE_DEFER, 4'hd, 8'h04);
    wr(`CMD_PHASE_DIRECT, 4'hc, 8'h00, 18);
    settle();
    look("extra edges", cls_up);
    load_phase(2, 12'h000);
    $display("test framing done");
  endtask

  task automatic t_freq();
    dds_pkg::dac_code_t s [8];
    wr(`CMD_FREQ_DEFER, 4'h6, 8'h00);
    wr(`CMD_FREQ_DIRECT, 4'h7, 8'h40);
    pick(2);
    look("word zero idle", cls_mid);
    step(5);
    look("five steps", cls_up);
    step(2);
    look("seven steps", cls_down);
    step(4);
    look("full wrap", cls_down);
    @(posedge clk_in);
    freq_word_select <= 1'b1;
    settle();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      #1 s[i] = dac_code;
    end
    for (int i = 0; i < 4; i++) check("period", 16'(s[i]), 16'(s[i + 4]));
    @(posedge clk_in);
    freq_word_select <= 1'b0;
    settle();
    $display("test frequency words done");
  endtask

  task automatic t_control();
    wr(4'hd, 4'h0, 8'h00);
    pick(0);
    look("after clear", cls_up);
    wr(4'he, 4'h0, 8'h00);
    wr(`CMD_BOTH_SEL, 4'h2, 8'h00);
    settle();
    look("select by bits", cls_down);
    wr(4'hd, 4'h0, 8'h00);
    settle();
    look("pins again", cls_up);
    $display("test select source done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_in           = 1'b1;
    freq_word_select = 1'b0;
    phase_sel_lo     = 1'b0;
    phase_sel_hi     = 1'b0;
    idle             = 1'b0;
    miscompares      = 0;
    n_tests          = 0;
    repeat (12) @(posedge clk_in);
    check("code in reset", 16'(dac_code), 16'(`LUT_MID));
    rst_in <= 1'b0;
    settle();
    check("code after reset", 16'(dac_code), 16'(`LUT_MID));
    $display("test reset done");
    t_phase();
    t_defer();
    t_frame();
    t_freq();
    t_control();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    conclude();
  end
endmodule
